// ==== include/ots_pkg.sv ====
// ots_pkg: constants and types of the over-travel, fault clear and drive enable sequencer.
// assumes a 10 MHz control clock and a plain strobe register port.
package ots_pkg;
	// ----------------------------------------
	// register port
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_FWD_SEL = 8'h00;    // forward limit terminal select
	localparam logic [7:0] OFS_REV_SEL = 8'h04;    // reverse limit terminal select
	localparam logic [7:0] OFS_CLR_SEL = 8'h08;    // fault clear terminal select
	localparam logic [7:0] OFS_ENA_SEL = 8'h0c;    // drive enable terminal select
	localparam logic [7:0] OFS_ACTION = 8'h10;     // travel limit action code
	localparam logic [7:0] OFS_SEQ_CAP = 8'h14;    // sequence torque cap, percent
	localparam logic [7:0] OFS_PEAK = 8'h18;       // peak motor torque, percent
	localparam logic [7:0] OFS_STATE = 8'h1c;      // read-only status
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;   // sticky events, write one to clear
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;   // event enables
	// ----------------------------------------
	// function selects: bits 2:0 terminal, bit 3 active low
	// ----------------------------------------
	localparam int SEL_W = 4;
	localparam int SEL_POL_BIT = 3;
	localparam int N_FN = 4;
	localparam int FN_FWD = 0;
	localparam int FN_REV = 1;
	localparam int FN_CLR = 2;
	localparam int FN_ENA = 3;
	localparam logic [3:0] FWD_SEL_RST = 4'h2;
	localparam logic [3:0] REV_SEL_RST = 4'h3;
	localparam logic [3:0] CLR_SEL_RST = 4'h1;
	localparam logic [3:0] ENA_SEL_RST = 4'h0;
	// ----------------------------------------
	// action codes
	// ----------------------------------------
	localparam logic [2:0] block_brake_stay_enabled = 3'h0;
	localparam logic [2:0] block_dynbrake_stay_enabled = 3'h1;
	localparam logic [2:0] block_coast_stay_enabled = 3'h2;
	localparam logic [2:0] block_brake_then_disable = 3'h3;
	localparam logic [2:0] block_dynbrake_then_disable = 3'h4;
	localparam logic [2:0] block_coast_then_disable = 3'h5;
	localparam logic [2:0] accept_cmd_zero_speed_cap = 3'h6;
	// ----------------------------------------
	// torque in percent
	// ----------------------------------------
	localparam int TQ_W = 10;
	localparam logic [9:0] CAP_MIN = 10'h00a;      // 10 percent
	localparam logic [9:0] CAP_MAX = 10'h1f4;      // 500 percent
	localparam logic [9:0] CAP_RST = 10'h12c;      // 300 percent
	localparam logic [9:0] PEAK_RST = 10'h12c;
	// ----------------------------------------
	// braking style and interrupt bits
	// ----------------------------------------
	localparam logic [1:0] BRK_NONE = 2'h0;
	localparam logic [1:0] BRK_SERVO = 2'h1;
	localparam logic [1:0] BRK_DYN = 2'h2;
	localparam logic [1:0] BRK_COAST = 2'h3;
	localparam int N_EV = 4;
	localparam int EV_FWD = 0;                     // forward limit reached
	localparam int EV_REV = 1;                     // reverse limit reached
	localparam int EV_STOP = 2;                    // limit stop finished
	localparam int EV_CLR = 3;                     // alarm cleared
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [4:0]
	{
		ST_OFF = 5'h01,
		ST_RUN = 5'h02,
		ST_STOP = 5'h04,
		ST_HOLD = 5'h08,
		ST_TRIP = 5'h10
	} ots_state_type;
endpackage

// ==== include/ots_fn_if.sv ====
// ots_fn_if: function selects out to the terminal mapper and valid conditions back.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
interface ots_fn_if;
	import ots_pkg::*;
	logic [SEL_W-1:0] sel [N_FN];   // per function terminal and polarity
	logic [N_FN-1:0] valid;         // per function valid condition
	modport map
	(
		input sel,
		output valid
	);
	modport core
	(
		output sel,
		input valid
	);
endinterface

// ==== src/ots_input_map.sv ====
// ots_input_map: synchronises the general input terminals and derives function valid levels.
// assumes terminals are asynchronous pins and selects come from the same clock.
`timescale 1ns/1ns
module ots_input_map
	import ots_pkg::*;
#(
	parameter int N_TERM = 8
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [N_TERM-1:0] terminal_in,
	ots_fn_if.map fn
);
	// ----------------------------------------
	// checks and helpers
	// ----------------------------------------
	if (N_TERM < 1 || N_TERM > 8)
	begin : g_chk
		$error("N_TERM must be 1 to 8");
	end
	// pick one terminal and apply its polarity
	function automatic logic pick(input logic [N_TERM-1:0] t, input logic [SEL_W-1:0] s);
		logic v;
		v = (32'(s[2:0]) < N_TERM) ? t[s[2:0]] : 1'b0;
		return v ^ s[SEL_POL_BIT];
	endfunction
	logic [N_TERM-1:0] meta_r;   // first stage, read by second only
	logic [N_TERM-1:0] sync_r;   // stable terminal levels
	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= terminal_in;
			sync_r <= meta_r;
		end
	end
	// ----------------------------------------
	// per function valid, once per cycle
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fn.valid <= '0;
		else
			for (int i = 0; i < N_FN; i++)
				fn.valid[i] <= pick(sync_r, fn.sel[i]);
	end
endmodule

// ==== src/ots_torque_cap.sv ====
// ots_torque_cap: effective sequence torque limit, bounded by range and motor peak.
// assumes setting values arrive from registers of the same clock.
`timescale 1ns/1ns
module ots_torque_cap
	import ots_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [TQ_W-1:0] sequence_torque_cap,
	input wire logic [TQ_W-1:0] peak_motor_torque,
	input wire logic apply,
	output logic cap_active,
	output logic [TQ_W-1:0] cap_value
);
	// keep a setting inside 10 to 500 percent
	function automatic logic [TQ_W-1:0] bound(input logic [TQ_W-1:0] v);
		if (v < CAP_MIN)
			return CAP_MIN;
		else if (v > CAP_MAX)
			return CAP_MAX;
		else
			return v;
	endfunction
	logic [TQ_W-1:0] want;   // bounded setting
	assign want = bound(sequence_torque_cap);
	// ----------------------------------------
	// registered limit, peak wins when lower
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_active <= 1'b0;
			cap_value <= CAP_RST;
		end
		else
		begin
			cap_active <= apply;
			cap_value <= (want > peak_motor_torque) ? peak_motor_torque : want;
		end
	end
endmodule

// ==== src/ots_sequencer.sv ====
// ots_sequencer: over-travel stop, sequence torque cap, fault clear and drive enable.
// assumes motor status, alarm and sequence inputs come from logic on the same clock.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
module ots_sequencer
	import ots_pkg::*;
#(
	parameter int N_TERM = 8
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [N_TERM-1:0] terminal_in,
	input wire logic motor_stopped,
	input wire logic alarm_event,
	input wire logic alarm_hard,
	input wire logic jog_active,
	input wire logic brake_standby,
	input wire logic servo_brake_op,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [DATA_W-1:0] bus_rdata,
	output logic position_command_block,
	output logic forward_move_block,
	output logic reverse_move_block,
	output logic speed_cap_zero,
	output logic [1:0] brake_mode,
	output logic drive_enabled,
	output logic torque_cap_active,
	output logic [TQ_W-1:0] torque_cap_value,
	output logic alarm_active,
	output logic irq
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_r;   // first release stage
	logic rst_n_r;      // reset used by the rest
	// release through two flops, assert at once
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// codes that stop by servo braking
	function automatic logic is_servo_brake(input logic [2:0] c);
		return (c == block_brake_stay_enabled) || (c == block_brake_then_disable);
	endfunction
	// codes that leave the drive on after the stop
	function automatic logic stays_on(input logic [2:0] c);
		return (c == block_brake_stay_enabled) || (c == block_dynbrake_stay_enabled)
			|| (c == block_coast_stay_enabled);
	endfunction
	// braking style of a stop code
	function automatic logic [1:0] style(input logic [2:0] c);
		case (c)
			block_brake_stay_enabled, block_brake_then_disable: return BRK_SERVO;
			block_dynbrake_stay_enabled, block_dynbrake_then_disable: return BRK_DYN;
			block_coast_stay_enabled, block_coast_then_disable: return BRK_COAST;
			default: return BRK_NONE;
		endcase
	endfunction
	// ----------------------------------------
	// settings and status registers
	// ----------------------------------------
	logic [SEL_W-1:0] fwd_sel_r;            // forward limit terminal
	logic [SEL_W-1:0] rev_sel_r;            // reverse limit terminal
	logic [SEL_W-1:0] clr_sel_r;            // fault clear terminal
	logic [SEL_W-1:0] ena_sel_r;            // drive enable terminal
	logic [2:0] action_r;                   // travel_limit_action_select
	logic [TQ_W-1:0] seq_cap_r;             // sequence_torque_cap
	logic [TQ_W-1:0] peak_r;                // peak_motor_torque
	logic [N_EV-1:0] irq_stat_r;            // sticky events
	logic [N_EV-1:0] irq_mask_r;            // event enables
	logic [N_EV-1:0] ev;                    // this cycle's events
	logic [N_EV-1:0] stat_nxt;              // next sticky value
	logic [DATA_W-1:0] rd_nxt;              // read mux
	// ----------------------------------------
	// terminal mapping
	// ----------------------------------------
	ots_fn_if fn_bus();
	assign fn_bus.sel[FN_FWD] = fwd_sel_r;
	assign fn_bus.sel[FN_REV] = rev_sel_r;
	assign fn_bus.sel[FN_CLR] = clr_sel_r;
	assign fn_bus.sel[FN_ENA] = ena_sel_r;
	ots_input_map #(
		.N_TERM(N_TERM)
	) u_map (
		.clock(clock),
		.rst_n(rst_n_r),
		.terminal_in(terminal_in),
		.fn(fn_bus.map)
	);
	logic forward_travel_limit;   // forward limit valid
	logic reverse_travel_limit;   // reverse limit valid
	logic fault_clear_input;      // fault clear valid
	logic drive_enable_signal;    // drive enable valid
	logic limit_any;              // either limit valid
	assign forward_travel_limit = fn_bus.valid[FN_FWD];
	assign reverse_travel_limit = fn_bus.valid[FN_REV];
	assign fault_clear_input = fn_bus.valid[FN_CLR];
	assign drive_enable_signal = fn_bus.valid[FN_ENA];
	assign limit_any = forward_travel_limit | reverse_travel_limit;
	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// settings, written by software only
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			fwd_sel_r <= FWD_SEL_RST;
			rev_sel_r <= REV_SEL_RST;
			clr_sel_r <= CLR_SEL_RST;
			ena_sel_r <= ENA_SEL_RST;
			action_r <= block_brake_stay_enabled;
			seq_cap_r <= CAP_RST;
			peak_r <= PEAK_RST;
			irq_mask_r <= '0;
		end
		else if (bus_wr)
		begin
			case (bus_addr)
				OFS_FWD_SEL: fwd_sel_r <= bus_wdata[SEL_W-1:0];
				OFS_REV_SEL: rev_sel_r <= bus_wdata[SEL_W-1:0];
				OFS_CLR_SEL: clr_sel_r <= bus_wdata[SEL_W-1:0];
				OFS_ENA_SEL: ena_sel_r <= bus_wdata[SEL_W-1:0];
				OFS_ACTION: action_r <= bus_wdata[2:0];
				OFS_SEQ_CAP: seq_cap_r <= bus_wdata[TQ_W-1:0];
				OFS_PEAK: peak_r <= bus_wdata[TQ_W-1:0];
				OFS_IRQ_MASK: irq_mask_r <= bus_wdata[N_EV-1:0];
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// alarm latch
	// ----------------------------------------
	logic alarm_r;        // any alarm standing
	logic alarm_hard_r;   // alarm needing a power cycle
	logic clr_prev_r;     // fault clear last cycle
	logic clr_rise;       // fault clear became valid
	assign clr_rise = fault_clear_input & ~clr_prev_r;
	// new alarms win over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			alarm_r <= 1'b0;
			alarm_hard_r <= 1'b0;
			clr_prev_r <= 1'b0;
		end
		else
		begin
			clr_prev_r <= fault_clear_input;
			if (alarm_event)
			begin
				alarm_r <= 1'b1;
				alarm_hard_r <= alarm_hard_r | alarm_hard;
			end
			else if (clr_rise && !alarm_hard_r)
				alarm_r <= 1'b0;
		end
	end
	// ----------------------------------------
	// stop sequencer
	// ----------------------------------------
	ots_state_type state_r;    // sequencer state
	ots_state_type state_nxt;  // next state
	logic go_off;              // lose enable or alarm
	// an alarm or lost enable wins over limit handling in every state but ST_TRIP, which waits for the limit to clear
	assign go_off = ~drive_enable_signal | alarm_r;
	// next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF:
				if (!go_off)
					state_nxt = ST_RUN;
			ST_RUN:
				if (go_off)
					state_nxt = ST_OFF;
				else if (limit_any && action_r != accept_cmd_zero_speed_cap
					&& action_r <= block_coast_then_disable)
					state_nxt = ST_STOP;
			ST_STOP:
				if (go_off)
					state_nxt = ST_OFF;
				else if (motor_stopped)
					state_nxt = stays_on(action_r) ? ST_HOLD : ST_TRIP;
			ST_HOLD:
				// enabled and blocked until the limit clears
				if (go_off)
					state_nxt = ST_OFF;
				else if (!limit_any)
					state_nxt = ST_RUN;
			ST_TRIP:
				// disabled until the limit clears, then re-arm from off
				if (!limit_any)
					state_nxt = ST_OFF;
			default:
				state_nxt = ST_OFF;
		endcase
	end
	// state register
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
			state_r <= ST_OFF;
		else
			state_r <= state_nxt;
	end
	// ----------------------------------------
	// motion outputs
	// ----------------------------------------
	logic in_stop;     // braking in progress
	logic servo_brk;   // stopping by servo braking
	assign in_stop = (state_r == ST_STOP);
	assign servo_brk = in_stop & is_servo_brake(action_r);
	// registered so outputs are glitch free toward the drive
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			position_command_block <= 1'b0;
			forward_move_block <= 1'b0;
			reverse_move_block <= 1'b0;
			speed_cap_zero <= 1'b0;
			brake_mode <= BRK_NONE;
			drive_enabled <= 1'b0;
		end
		else
		begin
			// blocked from the stop until the limit clears
			position_command_block <= (state_nxt == ST_STOP) || (state_nxt == ST_HOLD)
				|| (state_nxt == ST_TRIP);
			// no travel past a limit in its direction
			forward_move_block <= forward_travel_limit;
			reverse_move_block <= reverse_travel_limit;
			// zero speed cap while limited, stay-on codes and code 06
			speed_cap_zero <= limit_any && (stays_on(action_r)
				|| action_r == accept_cmd_zero_speed_cap);
			brake_mode <= (state_nxt == ST_STOP) ? style(action_r) : BRK_NONE;
			drive_enabled <= (state_nxt == ST_RUN) || (state_nxt == ST_STOP)
				|| (state_nxt == ST_HOLD);
		end
	end
	assign alarm_active = alarm_r;
	// ----------------------------------------
	// sequence torque cap
	// ----------------------------------------
	logic cap_apply;   // any sequence needing the cap
	// limit stop by servo braking, jog, brake standby, servo brake
	assign cap_apply = servo_brk | jog_active | brake_standby | servo_brake_op;
	ots_torque_cap u_cap (
		.clock(clock),
		.rst_n(rst_n_r),
		.sequence_torque_cap(seq_cap_r),
		.peak_motor_torque(peak_r),
		.apply(cap_apply),
		.cap_active(torque_cap_active),
		.cap_value(torque_cap_value)
	);
	// ----------------------------------------
	// interrupt events
	// ----------------------------------------
	logic fwd_prev_r;   // forward limit last cycle
	logic rev_prev_r;   // reverse limit last cycle
	// edge memory for limit events
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			fwd_prev_r <= 1'b0;
			rev_prev_r <= 1'b0;
		end
		else
		begin
			fwd_prev_r <= forward_travel_limit;
			rev_prev_r <= reverse_travel_limit;
		end
	end
	// event sources
	always_comb
	begin
		ev = '0;
		ev[EV_FWD] = forward_travel_limit & ~fwd_prev_r;
		ev[EV_REV] = reverse_travel_limit & ~rev_prev_r;
		ev[EV_STOP] = in_stop & ~go_off & motor_stopped;
		ev[EV_CLR] = alarm_r & ~alarm_event & clr_rise & ~alarm_hard_r;
	end
	// write one to clear, but a new event keeps its bit
	always_comb
	begin
		stat_nxt = irq_stat_r;
		if (bus_wr && bus_addr == OFS_IRQ_STAT)
			stat_nxt = stat_nxt & ~bus_wdata[N_EV-1:0];
		stat_nxt = stat_nxt | ev;
	end
	// sticky status
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
			irq_stat_r <= '0;
		else
			irq_stat_r <= stat_nxt;
	end
	assign irq = |(irq_stat_r & irq_mask_r);
	// ----------------------------------------
	// register reads
	// ----------------------------------------
	// unmapped addresses read zero
	always_comb
	begin
		rd_nxt = '0;
		case (bus_addr)
			OFS_FWD_SEL: rd_nxt[SEL_W-1:0] = fwd_sel_r;
			OFS_REV_SEL: rd_nxt[SEL_W-1:0] = rev_sel_r;
			OFS_CLR_SEL: rd_nxt[SEL_W-1:0] = clr_sel_r;
			OFS_ENA_SEL: rd_nxt[SEL_W-1:0] = ena_sel_r;
			OFS_ACTION: rd_nxt[2:0] = action_r;
			OFS_SEQ_CAP: rd_nxt[TQ_W-1:0] = seq_cap_r;
			OFS_PEAK: rd_nxt[TQ_W-1:0] = peak_r;
			OFS_STATE: rd_nxt[15:0] = {fn_bus.valid, alarm_hard_r, alarm_r, brake_mode,
				drive_enabled, speed_cap_zero, position_command_block, state_r};
			OFS_IRQ_STAT: rd_nxt[N_EV-1:0] = irq_stat_r;
			OFS_IRQ_MASK: rd_nxt[N_EV-1:0] = irq_mask_r;
			default: rd_nxt = '0;
		endcase
	end
	// read data only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n_r)
	begin
		if (!rst_n_r)
			bus_rdata <= '0;
		else if (bus_rd)
			bus_rdata <= rd_nxt;
		else
			bus_rdata <= '0;
	end
endmodule

// ==== testbench/ots_sequencer_checker.sv ====
// ots_sequencer_checker: timing relations seen at the sequencer's top ports.
// assumes it is bound into ots_sequencer and shares its clock and raw reset.
`timescale 1ns/1ns
module ots_sequencer_checker
	import ots_pkg::*;
#(
	parameter int N_TERM = 8
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic bus_rd,
	input wire logic [DATA_W-1:0] bus_rdata,
	input wire logic alarm_event,
	input wire logic motor_stopped,
	input wire logic jog_active,
	input wire logic brake_standby,
	input wire logic servo_brake_op,
	input wire logic position_command_block,
	input wire logic [1:0] brake_mode,
	input wire logic drive_enabled,
	input wire logic torque_cap_active,
	input wire logic [TQ_W-1:0] torque_cap_value,
	input wire logic alarm_active
);
	// ----------------------------------------
	// shared clocking and sequences
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_stopping;  // a limit stop is braking the axis
		brake_mode != BRK_NONE;
	endsequence
	sequence s_cap_demand;  // a sequence that wants the torque cap, held a while
		(jog_active || brake_standby || servo_brake_op) [*3];
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rd_idle;
		!$past(bus_rd) |-> bus_rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_brake_enabled;
		s_stopping |-> drive_enabled && position_command_block;
	endproperty
	a_brake_enabled: assert property (p_brake_enabled) else $error("braking without block or drive");
	property p_brake_ends;
		s_stopping ##0 motor_stopped |-> ##[1:3] brake_mode == BRK_NONE;
	endproperty
	a_brake_ends: assert property (p_brake_ends) else $error("braking kept after rest");
	property p_servo_cap;
		$rose(brake_mode == BRK_SERVO) |-> ##[0:2] torque_cap_active;
	endproperty
	a_servo_cap: assert property (p_servo_cap) else $error("servo braking without torque cap");
	property p_cap_range;
		torque_cap_active |-> torque_cap_value >= CAP_MIN && torque_cap_value <= CAP_MAX;
	endproperty
	a_cap_range: assert property (p_cap_range) else $error("torque cap out of range");
	property p_seq_cap;
		s_cap_demand |-> torque_cap_active;
	endproperty
	a_seq_cap: assert property (p_seq_cap) else $error("sequence without torque cap");
	property p_alarm_set;
		alarm_event |=> alarm_active;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched");
	property p_alarm_drops;
		alarm_event |-> ##[1:3] !drive_enabled;
	endproperty
	a_alarm_drops: assert property (p_alarm_drops) else $error("drive kept on alarm");
endmodule

// ==== testbench/ots_host_model.sv ====
// ots_host_model: host terminals and axis mechanics at the sequencer's far side.
// assumes the bench sets term_req and slow on the device clock.
`timescale 1ns/1ns
module ots_host_model
	import ots_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] term_req,
	input wire logic slow,
	input wire logic [1:0] brake_mode,
	output logic [7:0] terminal_in,
	output logic motor_stopped
);
	logic [5:0] brake_cnt_r;  // cycles spent braking so far
	// terminals move just after an edge and then hold for whole cycles
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			terminal_in <= 8'h00;
		else
			terminal_in <= term_req;
	end
	// axis needs a while to reach rest, longer when slow is set
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			brake_cnt_r <= 6'h00;
			motor_stopped <= 1'b0;
		end
		else if (brake_mode == BRK_NONE)
		begin
			brake_cnt_r <= 6'h00;
			motor_stopped <= 1'b0;
		end
		else
		begin
			brake_cnt_r <= brake_cnt_r + 6'h01;
			motor_stopped <= brake_cnt_r >= (slow ? 6'h18 : 6'h0a);
		end
	end
endmodule

// ==== testbench/ots_sequencer_tb.sv ====
// ots_sequencer_tb: register, limit stop, torque cap and alarm tests of the sequencer.
// assumes the host model on the terminals and a 10 MHz clock.
`timescale 1ns/1ns
module ots_sequencer_tb;
	import ots_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, alarm_event = 1'b0, alarm_hard = 1'b0;
	logic jog_active = 1'b0, brake_standby = 1'b0, servo_brake_op = 1'b0, slow = 1'b0;
	logic bus_wr = 1'b0, bus_rd = 1'b0, motor_stopped, irq, alarm_active, drive_enabled;
	logic [ADDR_W-1:0] bus_addr = '0;
	logic [DATA_W-1:0] bus_wdata = '0, bus_rdata;
	logic [7:0] term_req = 8'h00, terminal_in;
	logic position_command_block, forward_move_block, reverse_move_block, speed_cap_zero;
	logic torque_cap_active;
	logic [1:0] brake_mode;
	logic [TQ_W-1:0] torque_cap_value;
	int n_errors = 0, compares = 0;
	// register offsets and reset values, last entry unmapped
	logic [7:0] ofs_tab [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
	logic [31:0] rst_tab [11] = '{32'h2, 32'h3, 32'h1, 32'h0, 32'h0, 32'h12c, 32'h12c, 32'h1, 32'h0, 32'h0, 32'h0};
	logic [1:0] brk_tab [8] = '{BRK_SERVO, BRK_DYN, BRK_COAST, BRK_SERVO, BRK_DYN, BRK_COAST, BRK_NONE, BRK_NONE};
	logic [9:0] cap_tab [3] = '{10'h190, 10'h005, 10'h258};
	logic [9:0] peak_tab [3] = '{10'h064, 10'h12c, 10'h200};
	logic [9:0] eff_tab [3] = '{10'h064, 10'h00a, 10'h1f4};
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	ots_sequencer #(.N_TERM(8)) uut (.clock(clock), .reset_n(reset_n), .terminal_in(terminal_in),
		.motor_stopped(motor_stopped), .alarm_event(alarm_event), .alarm_hard(alarm_hard),
		.jog_active(jog_active), .brake_standby(brake_standby), .servo_brake_op(servo_brake_op),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.position_command_block(position_command_block), .forward_move_block(forward_move_block),
		.reverse_move_block(reverse_move_block), .speed_cap_zero(speed_cap_zero), .brake_mode(brake_mode),
		.drive_enabled(drive_enabled), .torque_cap_active(torque_cap_active),
		.torque_cap_value(torque_cap_value), .alarm_active(alarm_active), .irq(irq));
	ots_host_model host (.clock(clock), .reset_n(reset_n), .term_req(term_req), .slow(slow),
		.brake_mode(brake_mode), .terminal_in(terminal_in), .motor_stopped(motor_stopped));
	// ----------------------------------------
	// clock, tasks and watchdog
	// ----------------------------------------
	initial
	begin
		forever #50 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cyc(input int n);  // ends 1 ns past an edge
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata & m, e);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the tests need well under 2000 cycles
	initial
	begin
		#500000;
		n_errors++;
		tally_and_finish();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		wait_cyc(3);
		wr(8'h30, 32'hffff_ffff);  // unmapped, must be dropped
		for (int i = 0; i < 11; i++)
			rd(ofs_tab[i], 32'hffff_ffff, rst_tab[i]);
		@(posedge clock) term_req[0] <= 1'b1;  // drive enable on terminal one
		wait_cyc(7);
		chk(drive_enabled, 1);
		rd(OFS_STATE, 32'h0000_ffff, 32'h0000_8082);
		// forward limit moved to terminal seven, active low
		@(posedge clock) term_req[6] <= 1'b1;
		wait_cyc(5);
		wr(OFS_FWD_SEL, 32'h0000_000e);
		for (int c = 0; c < 8; c++)
		begin
			wr(OFS_ACTION, 32'(c));
			@(posedge clock)
			begin
				slow <= c[0];
				term_req[6] <= 1'b0;
			end
			wait_cyc(7);
			chk(forward_move_block, 1);
			chk(position_command_block, 32'(c < 6));
			chk(brake_mode, brk_tab[c]);
			chk(speed_cap_zero, 32'(c inside {0, 1, 2, 6}));
			chk(torque_cap_active, 32'(c == 0 || c == 3));
			wait_cyc(40);
			chk(brake_mode, BRK_NONE);
			chk(drive_enabled, 32'(!(c inside {3, 4, 5})));
			@(posedge clock) term_req[6] <= 1'b1;
			wait_cyc(12);
			chk(drive_enabled, 1);
			chk(forward_move_block, 0);
		end
		@(posedge clock) term_req[3] <= 1'b1;  // reverse limit, code 07: no stop
		wait_cyc(7);
		chk(reverse_move_block, 1);
		chk(position_command_block, 0);
		@(posedge clock) term_req[3] <= 1'b0;
		// cap bounded by range and by the peak, one case each for jog, brake standby and servo brake
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_SEQ_CAP, 32'(cap_tab[i]));
			wr(OFS_PEAK, 32'(peak_tab[i]));
			@(posedge clock) {servo_brake_op, brake_standby, jog_active} <= 3'(1 << i);
			wait_cyc(4);
			chk(torque_cap_active, 1);
			chk(torque_cap_value, eff_tab[i]);
			@(posedge clock) {servo_brake_op, brake_standby, jog_active} <= 3'h0;
			wait_cyc(3);
		end
		// clearable alarm, then interrupt raise, mask and clear
		@(posedge clock) alarm_event <= 1'b1;
		@(posedge clock) alarm_event <= 1'b0;
		wait_cyc(3);
		chk(alarm_active, 1);
		chk(drive_enabled, 0);
		@(posedge clock) term_req[1] <= 1'b1;
		wait_cyc(7);
		chk(alarm_active, 0);
		chk(drive_enabled, 1);
		chk(irq, 0);  // events pending but masked
		wr(OFS_IRQ_MASK, 32'h0000_0008);
		wait_cyc(1);
		chk(irq, 1);
		wr(OFS_IRQ_STAT, 32'h0000_000f);
		wait_cyc(1);
		chk(irq, 0);
		// alarm that needs a power cycle survives the clear input
		@(posedge clock) {alarm_event, alarm_hard, term_req[1]} <= 3'b110;
		@(posedge clock) {alarm_event, alarm_hard} <= 2'b00;
		wait_cyc(6);
		@(posedge clock) term_req[1] <= 1'b1;
		wait_cyc(7);
		chk(alarm_active, 1);
		tally_and_finish();
	end
endmodule

bind ots_sequencer ots_sequencer_checker #(.N_TERM(N_TERM)) u_chk (.clock(clock), .reset_n(reset_n),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .alarm_event(alarm_event), .motor_stopped(motor_stopped),
	.jog_active(jog_active), .brake_standby(brake_standby), .servo_brake_op(servo_brake_op),
	.position_command_block(position_command_block), .brake_mode(brake_mode), .drive_enabled(drive_enabled),
	.torque_cap_active(torque_cap_active), .torque_cap_value(torque_cap_value), .alarm_active(alarm_active));
